// ==== smbsp_port.sv ====
// two-wire management bus slave port with pointer, config and alert
// ******************************************************************
// ******************************************************************
`timescale 1ns/1ps
module smbsp_port #(
  // shorten for simulation
  parameter int unsigned TIMEOUT_CYCLES = int'(smbsp_pkg::TIMEOUT_CYC)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // bus clock from the master, also the link domain clock
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // open-drain alert, enable high pulls the line low
  output logic alert_o,
  output logic alert_oe,
  // address straps
  input wire logic addr_en_i,
  input wire logic addr_sel_i,
  // alert cause from the limit logic, same clock
  input wire logic alert_cond_i,
  // read port toward the other registers
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // write strobe toward the other registers
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  // ****************************************************************
  // constants and state
  // ****************************************************************
  localparam logic [smbsp_pkg::TO_W-1:0] TO_LIMIT =
    TIMEOUT_CYCLES[smbsp_pkg::TO_W-1:0];

  // all state of the port in one record
  typedef struct packed {
    smbsp_pkg::smbsp_state_e state;
    logic [3:0] cnt;        // bits done in the current byte
    logic [7:0] sh;         // receive shifter
    logic [7:0] txd;        // transmit shifter
    logic [1:0] nbytes;     // write bytes seen after the address
    logic rd;               // current transfer is a read
    logic ack_on;           // ack already driven in this slot
    logic [7:0] ptr;        // register pointer
    logic [7:0] cfg;        // configuration register one
    logic sda_oe;           // pulling the data line low
    logic alert_oe;         // pulling the alert line low
    logic ara;              // current read answers the alert address
    logic ara_done;         // alert address answered
    logic busy;             // between start and stop
    logic [smbsp_pkg::TO_W-1:0] to_cnt;
    logic lock;             // slave address frozen
    logic [6:0] own_addr;   // active slave address
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic scl_prev;
    logic sda_prev;
    logic tog_prev;
    logic low;              // constant low drive level
  } smbsp_port_s;

  smbsp_port_s r_q;
  smbsp_port_s r_d;

  // ****************************************************************
  // crossings
  // ****************************************************************
  logic bit_val;            // sampled data bit, valid after toggle
  logic bit_tog;            // flips on each bus clock rise
  logic [4:0] sync_v;       // synchronised pins and toggle
  logic scl_s;
  logic sda_s;
  logic tog_s;
  logic en_s;
  logic sel_s;

  // bit capture on the bus clock itself
  smbsp_link u_link (
    .scl_clk(scl_i),
    .resetn(resetn),
    .sda_i(sda_i),
    .bit_val(bit_val),
    .bit_tog(bit_tog)
  );

  // every pin and the toggle pass two flops
  smbsp_sync #(.W(5)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({scl_i, sda_i, bit_tog, addr_en_i, addr_sel_i}),
    .sync_out(sync_v)
  );

  assign {scl_s, sda_s, tog_s, en_s, sel_s} = sync_v;

  // ****************************************************************
  // next state
  // ****************************************************************
  logic start_evt;
  logic stop_evt;
  logic scl_fall;
  logic bit_evt;
  logic bus_edge;
  logic to_fire;
  logic [7:0] rx_byte;
  logic [6:0] strap_addr;
  logic [7:0] rd_sel;

  // bus conditions seen on synchronised levels
  always_comb begin
    start_evt = scl_s & r_q.scl_prev & r_q.sda_prev & ~sda_s;
    stop_evt = scl_s & r_q.scl_prev & ~r_q.sda_prev & sda_s;
    scl_fall = r_q.scl_prev & ~scl_s;
    // toggle and value are stable for a bus period, far above sync delay
    bit_evt = tog_s ^ r_q.tog_prev;
    bus_edge = (scl_s ^ r_q.scl_prev) | (sda_s ^ r_q.sda_prev);
    rx_byte = {r_q.sh[6:0], bit_val};
    if (en_s) begin
      strap_addr = smbsp_pkg::ADDR_DEFAULT;
    end else if (sel_s) begin
      strap_addr = smbsp_pkg::ADDR_SEL_HI;
    end else begin
      strap_addr = smbsp_pkg::ADDR_SEL_LO;
    end
    if (r_q.ptr == smbsp_pkg::CFG_ONE_OFS) begin
      rd_sel = r_q.cfg;
    end else begin
      rd_sel = rd_data;
    end
    // bit six set means no timeout
    to_fire = r_q.busy & (r_q.to_cnt == TO_LIMIT)
      & ~r_q.cfg[smbsp_pkg::BUS_TIMEOUT_DISABLE_BIT];
  end

  // the whole port decision in one place
  always_comb begin
    r_d = r_q;
    r_d.wr_stb = 1'b0;
    r_d.low = 1'b0;
    r_d.scl_prev = scl_s;
    r_d.sda_prev = sda_s;
    r_d.tog_prev = tog_s;
    // straps followed only until the first match
    if (!r_q.lock) begin
      r_d.own_addr = strap_addr;
    end
    // restart on edges, hold cleared while idle
    if (!r_q.busy || bus_edge) begin
      r_d.to_cnt = '0;
    end else if (r_q.to_cnt != TO_LIMIT) begin
      r_d.to_cnt = r_q.to_cnt + 1'b1;
    end
    // cause wins over release in the same cycle
    if (alert_cond_i) begin
      r_d.alert_oe = 1'b1;
    end else if (r_q.ara_done) begin
      r_d.alert_oe = 1'b0;
      r_d.ara_done = 1'b0;
    end
    // a start anywhere, repeated or not, restarts decoding
    if (start_evt) begin
      r_d.busy = 1'b1;
      r_d.state = smbsp_pkg::SMBSP_ADDR;
      r_d.cnt = '0;
      r_d.sda_oe = 1'b0;
      r_d.ack_on = 1'b0;
      r_d.ara = 1'b0;
      r_d.nbytes = '0;
    end else if (stop_evt) begin
      // stop ends everything and idles the timeout
      r_d.busy = 1'b0;
      r_d.state = smbsp_pkg::SMBSP_IDLE;
      r_d.sda_oe = 1'b0;
    end else if (to_fire) begin
      // bus assumed locked, let go of it
      r_d.busy = 1'b0;
      r_d.state = smbsp_pkg::SMBSP_IDLE;
      r_d.sda_oe = 1'b0;
    end else begin
      case (r_q.state)
        // address byte plus direction bit
        smbsp_pkg::SMBSP_ADDR: begin
          if (bit_evt) begin
            r_d.sh = rx_byte;
            r_d.cnt = r_q.cnt + 1'b1;
            if (r_q.cnt == smbsp_pkg::LAST_BIT) begin
              r_d.cnt = '0;
              if (rx_byte[7:1] == r_q.own_addr) begin
                r_d.lock = 1'b1;
                r_d.state = smbsp_pkg::SMBSP_ACK;
                r_d.rd = rx_byte[0];
                // read byte taken at address time
                r_d.txd = rd_sel;
              end else if (rx_byte[7:1] == smbsp_pkg::ARA_ADDR && rx_byte[0]
                           && r_q.alert_oe) begin
                r_d.state = smbsp_pkg::SMBSP_ACK;
                r_d.rd = 1'b1;
                r_d.ara = 1'b1;
                r_d.txd = {r_q.own_addr, 1'b0};
              end else begin
                // not ours, wait for the next start
                r_d.state = smbsp_pkg::SMBSP_IDLE;
              end
            end
          end
        end
        // ack slot: pull on the fall; on the next fall release, or for a read drive the first data bit
        smbsp_pkg::SMBSP_ACK: begin
          if (scl_fall) begin
            if (!r_q.ack_on) begin
              r_d.sda_oe = 1'b1;
              r_d.ack_on = 1'b1;
            end else begin
              r_d.ack_on = 1'b0;
              r_d.cnt = '0;
              if (r_q.rd) begin
                // first data bit goes out on this same fall
                r_d.sda_oe = ~r_q.txd[7];
                r_d.state = smbsp_pkg::SMBSP_TX;
              end else begin
                r_d.sda_oe = 1'b0;
                r_d.state = smbsp_pkg::SMBSP_WDATA;
              end
            end
          end
        end
        // pointer byte, then data byte
        smbsp_pkg::SMBSP_WDATA: begin
          if (bit_evt) begin
            r_d.sh = rx_byte;
            r_d.cnt = r_q.cnt + 1'b1;
            if (r_q.cnt == smbsp_pkg::LAST_BIT) begin
              r_d.cnt = '0;
              r_d.nbytes = r_q.nbytes + 1'b1;
              if (r_q.nbytes == 2'h0) begin
                // first byte is always the pointer
                r_d.ptr = rx_byte;
                r_d.state = smbsp_pkg::SMBSP_ACK;
              end else if (r_q.nbytes == 2'h1) begin
                // second byte lands in the pointed register
                if (r_q.ptr == smbsp_pkg::CFG_ONE_OFS) begin
                  r_d.cfg = rx_byte;
                end
                r_d.wr_stb = 1'b1;
                r_d.wr_addr = r_q.ptr;
                r_d.wr_data = rx_byte;
                r_d.state = smbsp_pkg::SMBSP_ACK;
              end else begin
                // a third byte is left unacked
                r_d.state = smbsp_pkg::SMBSP_IDLE;
              end
            end
          end
        end
        // one byte out, msb first
        smbsp_pkg::SMBSP_TX: begin
          if (bit_evt) begin
            if (!r_q.sda_oe && r_q.txd[7] && !bit_val) begin
              // someone lower won, drop out quietly
              r_d.sda_oe = 1'b0;
              r_d.ara = 1'b0;
              r_d.state = smbsp_pkg::SMBSP_IDLE;
            end else begin
              r_d.txd = {r_q.txd[6:0], 1'b0};
              r_d.cnt = r_q.cnt + 1'b1;
            end
          end else if (scl_fall) begin
            if (r_q.cnt == smbsp_pkg::BYTE_DONE) begin
              r_d.sda_oe = 1'b0;
              r_d.state = smbsp_pkg::SMBSP_MACK;
            end else begin
              r_d.sda_oe = ~r_q.txd[7];
            end
          end
        end
        // master ack or not-ack ends the single read byte
        smbsp_pkg::SMBSP_MACK: begin
          if (bit_evt) begin
            r_d.state = smbsp_pkg::SMBSP_IDLE;
            if (r_q.ara) begin
              r_d.ara_done = 1'b1;
            end
            r_d.ara = 1'b0;
          end
        end
        default: begin
          r_d.state = smbsp_pkg::SMBSP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // constants only under reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
      r_q.state <= smbsp_pkg::SMBSP_IDLE;
      r_q.cfg <= smbsp_pkg::CFG_ONE_RST;
      r_q.ptr <= smbsp_pkg::PTR_RST;
      r_q.own_addr <= smbsp_pkg::ADDR_DEFAULT;
      r_q.scl_prev <= 1'b1;
      r_q.sda_prev <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops
  assign sda_o = r_q.low;
  assign sda_oe = r_q.sda_oe;
  // alert drives only low, never high
  assign alert_o = r_q.low;
  assign alert_oe = r_q.alert_oe;
  assign rd_addr = r_q.ptr;
  assign wr_stb = r_q.wr_stb;
  assign wr_addr = r_q.wr_addr;
  assign wr_data = r_q.wr_data;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_wr_uses_ptr: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_q.wr_stb |-> (r_q.wr_addr == $past(r_q.ptr)) && r_q.state == smbsp_pkg::SMBSP_ACK)
    else $error("write strobe not tied to pointer");

  chk_ptr_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    $changed(r_q.ptr) |-> r_q.nbytes == 2'h1 && !r_q.wr_stb)
    else $error("pointer changed outside first write byte");

  chk_third_nack: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_q.state == smbsp_pkg::SMBSP_ACK && !r_q.rd |-> r_q.nbytes <= 2'h2)
    else $error("acked beyond two write bytes");

  chk_start_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    start_evt |=> r_q.state == smbsp_pkg::SMBSP_ADDR && !r_q.sda_oe && r_q.cnt == 4'h0)
    else $error("start did not restart address phase");

  chk_timeout_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    to_fire && !start_evt && !stop_evt |=> !r_q.sda_oe && !r_q.busy
      && r_q.state == smbsp_pkg::SMBSP_IDLE)
    else $error("timeout did not release the bus");

  chk_timeout_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_q.cfg[smbsp_pkg::BUS_TIMEOUT_DISABLE_BIT] && r_q.busy && !stop_evt |=> r_q.busy)
    else $error("bus dropped while timeout disabled");

  chk_idle_cleared: assert property (@(posedge sys_clk) disable iff (!resetn)
    !r_q.busy ##1 !r_q.busy |-> r_q.to_cnt == '0)
    else $error("timeout counter ran while idle");

  chk_addr_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_q.lock |=> $stable(r_q.own_addr))
    else $error("slave address moved after lock");

  chk_strap_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
    !r_q.lock |=> r_q.own_addr == $past(strap_addr))
    else $error("slave address not following straps");

  chk_ara_alert: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(r_q.ara) |-> $past(r_q.alert_oe) && r_q.txd == {r_q.own_addr, 1'b0})
    else $error("alert address answered without alert");

  chk_alert_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(r_q.alert_oe) |-> $past(r_q.ara_done) && !$past(alert_cond_i))
    else $error("alert released too early");

  chk_arb_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_q.state == smbsp_pkg::SMBSP_TX && bit_evt && !start_evt && !stop_evt && !to_fire
      && !r_q.sda_oe && r_q.txd[7] && !bit_val |=> !r_q.sda_oe ##1 !r_q.sda_oe)
    else $error("kept driving after lost arbitration");

endmodule : smbsp_port

// ==== smbsp_pkg.sv ====
// shared constants and types for the bus slave register port
package smbsp_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  // configuration register one, reached through the pointer
  localparam logic [7:0] CFG_ONE_OFS = 8'h40;
  // configuration register one after reset, timeout enabled
  localparam logic [7:0] CFG_ONE_RST = 8'h00;
  // bit position of bus_timeout_disable inside configuration one
  localparam int unsigned BUS_TIMEOUT_DISABLE_BIT = 6;
  // pointer after reset
  localparam logic [7:0] PTR_RST = 8'h00;

  // ****************************************************************
  // bus addresses
  // ****************************************************************
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2E;
  localparam logic [6:0] ADDR_SEL_LO = 7'h2C;
  localparam logic [6:0] ADDR_SEL_HI = 7'h2D;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint unsigned SYS_CLK_HZ = 50_000_000;
  // bus inactivity limit in milliseconds
  localparam longint unsigned TIMEOUT_MS = 25;
  // longest time, so the division rounds down
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_MS * SYS_CLK_HZ / 1000;
  // width of the inactivity counter
  localparam int unsigned TO_W = 21;
  // index of the last bit of a byte
  localparam logic [3:0] LAST_BIT = 4'h7;
  // count after all eight bits were shifted out
  localparam logic [3:0] BYTE_DONE = 4'h8;

  // transfer phases, gray coded along the write path
  typedef enum logic [2:0] {
    SMBSP_IDLE  = 3'b000,
    SMBSP_ADDR  = 3'b001,
    SMBSP_ACK   = 3'b011,
    SMBSP_WDATA = 3'b010,
    SMBSP_TX    = 3'b110,
    SMBSP_MACK  = 3'b111
  } smbsp_state_e;

endpackage : smbsp_pkg

// ==== smbsp_sync.sv ====
// two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module smbsp_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // first stage is read only by the second stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smbsp_sync_s;

  smbsp_sync_s r_q;
  smbsp_sync_s r_d;

  // shift the level one stage per edge
  always_comb begin
    r_d = r_q;
    r_d.s1 = async_in;
    r_d.s2 = r_q.s1;
  end

  // constants only under reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_out = r_q.s2;

endmodule : smbsp_sync

// ==== smbsp_link.sv ====
// bit capture on the bus clock, handed over as value plus toggle
`timescale 1ns/1ps
module smbsp_link (
  input wire logic scl_clk,
  input wire logic resetn,
  input wire logic sda_i,
  output logic bit_val,
  output logic bit_tog
);

  // value stays put for a whole bus clock, so it rides on the toggle
  typedef struct packed {
    logic val;
    logic tog;
  } smbsp_link_s;

  smbsp_link_s r_q;
  smbsp_link_s r_d;

  // sample the data line on each rising bus clock edge
  always_comb begin
    r_d = r_q;
    r_d.val = sda_i;
    r_d.tog = ~r_q.tog;
  end

  // the bus clock stops between frames; nothing here waits for it
  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign bit_val = r_q.val;
  assign bit_tog = r_q.tog;

endmodule : smbsp_link

// ==== smbsp_master.sv ====
// two-wire bus master model driving the port from the far side
`timescale 1ns/1ps
module smbsp_master #(
  // quarter of one bus bit time in ns
  parameter int Q = 40
) (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  // ****************************************************************
  // bus phases
  // ****************************************************************
  // clock stands high and data released outside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // data changes only while the clock is low
  task automatic put_bit(input logic b);
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask : put_bit

  // clash pulls low as a rival device would
  task automatic get_bit(input logic clash, output logic b);
    #Q sda_pull = clash;
    #Q scl = 1'b1;
    #Q b = sda_line;
    #Q scl = 1'b0;
  endtask : get_bit

  task automatic start;
    // odd lead so bus edges drift against the system clock
    #7 sda_pull = 1'b0;
    #(2*Q) scl = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask : start

  task automatic stop;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b0;
    #(2*Q);
  endtask : stop

  // stall holds the clock low inside the ack bit, in ns
  task automatic wbyte(input logic [7:0] d, input int stall, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    sda_pull = 1'b0;
    #(stall);
    get_bit(1'b0, b);
    ack = ~b;
  endtask : wbyte

  task automatic rbyte(input logic [7:0] mask, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(mask[i], d[i]);
    end
    put_bit(1'b1);
  endtask : rbyte
endmodule : smbsp_master

// ==== tb_smbsp_port.sv ====
// self-checking bench for the bus slave register port
`timescale 1ns/1ps
module tb_smbsp_port;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int TO = 200; // shortened timeout in sys_clk cycles
  localparam logic [7:0] W = {smbsp_pkg::ADDR_DEFAULT, 1'b0};
  localparam logic [7:0] R = {smbsp_pkg::ADDR_DEFAULT, 1'b1};
  localparam logic [7:0] ARA_R = {smbsp_pkg::ARA_ADDR, 1'b1};
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic addr_en_i = 1'b1;
  logic addr_sel_i = 1'b0;
  logic alert_cond_i = 1'b0;
  logic scl, m_pull, sda_o, sda_oe, alert_o, alert_oe, wr_stb;
  logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
  logic [7:0] cap_a = 8'h00; // last strobed write address
  logic [7:0] cap_d = 8'h00; // last strobed write data
  wire sda_line;
  wire alert_line;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int n_stb = 0;

  // pull-ups on both shared lines
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~m_pull;
  assign alert_line = alert_oe ? alert_o : 1'b1;
  // register file stand-in, distinct per address
  assign rd_data = rd_addr ^ 8'hA5;

  always #10 sys_clk = ~sys_clk;

  smbsp_port #(.TIMEOUT_CYCLES(TO)) i_smbsp_port (.sys_clk(sys_clk), .resetn(resetn),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
    .alert_oe(alert_oe), .addr_en_i(addr_en_i), .addr_sel_i(addr_sel_i),
    .alert_cond_i(alert_cond_i), .rd_addr(rd_addr), .rd_data(rd_data), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data));

  smbsp_master i_smbsp_master (.scl(scl), .sda_pull(m_pull), .sda_line(sda_line));

  // ****************************************************************
  // monitors and helpers
  // ****************************************************************
  // capture strobed writes, watchdog against hangs
  always @(posedge sys_clk) begin
    cycles++;
    if (wr_stb === 1'b1) begin
      cap_a <= wr_addr;
      cap_d <= wr_data;
      n_stb++;
    end
    if (cycles == 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one byte out, ack compared with the expected answer
  task automatic wb(input logic [7:0] d, input logic exp_ack, input string nm);
    logic a;
    i_smbsp_master.wbyte(d, 0, a);
    check(nm, {7'h00, a}, {7'h00, exp_ack});
  endtask : wb

  // start, read header, one byte back, stop
  task automatic rd(input logic [7:0] hdr, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    i_smbsp_master.start();
    wb(hdr, 1'b1, "read header ack");
    i_smbsp_master.rbyte(mask, d);
    i_smbsp_master.stop();
    check("read byte", d, exp);
  endtask : rd

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    i_smbsp_master.start();
    wb(W, 1'b1, "write header ack");
    wb(ptr, 1'b1, "pointer ack");
    wb(d, 1'b1, "data ack");
    i_smbsp_master.stop();
  endtask : wr

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    check("sda_oe", {7'h00, sda_oe}, 8'h00);
    check("alert_oe", {7'h00, alert_oe}, 8'h00);
    check("wr_stb", {7'h00, wr_stb}, 8'h00);
    check("rd_addr", rd_addr, smbsp_pkg::PTR_RST);
  endtask : t_reset

  // pointer-only write then repeated start read, then config write
  task automatic t_cfg;
    i_smbsp_master.start();
    wb(W, 1'b1, "header ack");
    wb(smbsp_pkg::CFG_ONE_OFS, 1'b1, "pointer ack");
    check("pointer", rd_addr, smbsp_pkg::CFG_ONE_OFS);
    rd(R, 8'h00, smbsp_pkg::CFG_ONE_RST);
    wr(smbsp_pkg::CFG_ONE_OFS, 8'h80);
    rd(R, 8'h00, 8'h80);
  endtask : t_cfg

  // ack held with clock stalled beyond the limit
  task automatic t_timeout(input logic [7:0] cfg, input logic exp_ack);
    logic a;
    wr(smbsp_pkg::CFG_ONE_OFS, cfg);
    i_smbsp_master.start();
    i_smbsp_master.wbyte(W, TO * 40, a);
    i_smbsp_master.stop();
    check("ack after stall", {7'h00, a}, {7'h00, exp_ack});
  endtask : t_timeout

  task automatic t_write;
    int n0;
    n0 = n_stb;
    wr(8'h44, 8'h3C);
    check("strobes one", 8'(n_stb - n0), 8'h01);
    check("strobe addr", cap_a, 8'h44);
    check("strobe data", cap_d, 8'h3C);
    check("pointer", rd_addr, 8'h44);
    rd(R, 8'h00, 8'h44 ^ 8'hA5);
    n0 = n_stb;
    i_smbsp_master.start();
    wb(W, 1'b1, "header ack");
    wb(8'h45, 1'b1, "pointer ack");
    wb(8'h11, 1'b1, "data ack");
    wb(8'h22, 1'b0, "third byte");
    i_smbsp_master.stop();
    check("strobes", 8'(n_stb - n0), 8'h01);
    check("strobe data", cap_d, 8'h11);
  endtask : t_write

  // reset in mid-run with select straps, then straps moved after the lock
  task automatic t_strap;
    @(posedge sys_clk);
    resetn <= 1'b0;
    addr_en_i <= 1'b0;
    addr_sel_i <= 1'b1;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_reset();
    i_smbsp_master.start();
    wb(W, 1'b0, "default addr off");
    i_smbsp_master.stop();
    i_smbsp_master.start();
    wb({smbsp_pkg::ADDR_SEL_HI, 1'b0}, 1'b1, "strap addr");
    i_smbsp_master.stop();
    @(posedge sys_clk);
    addr_sel_i <= 1'b0;
    repeat (8) @(posedge sys_clk);
    i_smbsp_master.start();
    wb({smbsp_pkg::ADDR_SEL_LO, 1'b0}, 1'b0, "moved strap addr");
    i_smbsp_master.stop();
    i_smbsp_master.start();
    wb({smbsp_pkg::ADDR_SEL_HI, 1'b0}, 1'b1, "frozen addr");
    i_smbsp_master.stop();
  endtask : t_strap

  task automatic t_ara;
    i_smbsp_master.start();
    wb(ARA_R, 1'b0, "ara idle");
    i_smbsp_master.stop();
    @(posedge sys_clk);
    alert_cond_i <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("alert line", {7'h00, alert_line}, 8'h00);
    rd(ARA_R, 8'h00, W);
    check("alert held", {7'h00, alert_oe}, 8'h01);
    rd(ARA_R, 8'h40, 8'h3F);
    // cause gone after the answer: released at once, alert address then ignored
    @(posedge sys_clk);
    alert_cond_i <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("alert released", {7'h00, alert_oe}, 8'h00);
    check("alert line free", {7'h00, alert_line}, 8'h01);
    i_smbsp_master.start();
    wb(ARA_R, 1'b0, "ara released");
    i_smbsp_master.stop();
  endtask : t_ara

  task automatic results;
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_reset();
    t_cfg();
    t_timeout(8'h80, 1'b0);
    t_timeout(8'h40, 1'b1);
    t_write();
    t_ara();
    t_strap();
    results();
  end
endmodule : tb_smbsp_port
